// [icm_pkg.sv]
`default_nettype none
package icm_pkg;
    localparam int ICM_DW = 32;
    localparam int ICM_AW = 8;
    localparam int ICM_NVEC = 5;
    localparam int ICM_VW = 3;
    localparam int ICM_IVL_W = 16;
    localparam int ICM_CNT_W = 11;
    localparam int ICM_REG_STRIDE = 4;
    // ========================================
    // register offsets
    localparam logic [7:0] ICM_OFS_CAUSE = 8'h00;
    localparam logic [7:0] ICM_OFS_CSET = 8'h04;
    localparam logic [7:0] ICM_OFS_MSET = 8'h08;
    localparam logic [7:0] ICM_OFS_MCLR = 8'h0C;
    localparam logic [7:0] ICM_OFS_ACLR = 8'h10;
    localparam logic [7:0] ICM_OFS_AMSK = 8'h14;
    localparam logic [7:0] ICM_OFS_VMAP = 8'h18;
    localparam logic [7:0] ICM_OFS_ECTL = 8'h1C;
    localparam logic [7:0] ICM_OFS_VCNT = 8'h20;
    localparam logic [7:0] ICM_OFS_THR0 = 8'h24;
    // ========================================
    // cause bit layout
    localparam int ICM_QLO = 20;
    localparam int ICM_NQ = 5;
    localparam int ICM_OTHER = 24;
    localparam logic [31:0] ICM_NONQ_MASK = 32'h0000_0204;
    localparam logic [31:0] ICM_QRANGE_MASK = 32'h01F0_0000;
    // ========================================
    // mapping table and extended control
    localparam int ICM_MAP_W = 4;
    localparam int ICM_MAP_EN = 3;
    localparam int ICM_VMAP_W = 20;
    localparam logic [19:0] ICM_VMAP_RST = 20'hCBA98;
    localparam int ICM_ECTL_W = 4;
    localparam int ICM_ECTL_AMME = 2;
    localparam int ICM_ECTL_PBA = 3;
    localparam logic [31:0] ICM_RST_ZERO = 32'h0000_0000;
    // ========================================
    // throttle time base
    localparam int ICM_CLK_NS = 20;
    localparam int ICM_THR_UNIT_NS = 256;
    localparam int ICM_TICK_CYC = ICM_THR_UNIT_NS / ICM_CLK_NS;
    localparam logic [7:0] ICM_TICK_LAST = 8'(ICM_TICK_CYC - 1);
    typedef enum logic [1:0] {
        ICM_MODE_LEGACY = 2'b00,
        ICM_MODE_MSI = 2'b01,
        ICM_MODE_MSIX = 2'b10,
        ICM_MODE_RSVD = 2'b11
    } icm_mode_type;
endpackage : icm_pkg
`default_nettype wire

// [icm_thr_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface icm_thr_if;
    import icm_pkg::*;
    logic [ICM_IVL_W-1:0] interval;
    logic tick;
    logic grant;
    logic zero;
    modport ctrl (output interval, output tick, output grant, input zero);
    modport thr (input interval, input tick, input grant, output zero);
endinterface : icm_thr_if
`default_nettype wire

// [icm_throttle.sv]
`timescale 1ns/100ps
`default_nettype none
module icm_throttle
    import icm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control side
    icm_thr_if.thr thr
);
    logic [ICM_IVL_W-1:0] cnt_r;
    logic [ICM_IVL_W-1:0] cnt_nxt;

    // ========================================
    // reload on a message, count down on ticks, rest at zero
    assign cnt_nxt = thr.grant ? thr.interval :
                     (thr.tick && (cnt_r != '0)) ? cnt_r - 1'b1 : cnt_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign thr.zero = (cnt_r == '0);
endmodule : icm_throttle
`default_nettype wire

// [icm_top.sv]
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module icm_top
    import icm_pkg::*;
#(
    parameter int VCNT_W = ICM_CNT_W
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [ICM_AW-1:0] reg_addr_i,
    input wire logic [ICM_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [ICM_DW-1:0] reg_rdata_o,
    // cause events
    input wire logic [ICM_DW-1:0] cause_event_i,
    // nonvolatile memory load
    input wire logic nvm_load_i,
    input wire logic [VCNT_W-1:0] nvm_vec_count_i,
    // host signalling
    output logic intx_o,
    output logic msg_req_o,
    output logic [ICM_VW-1:0] msg_vector_o,
    output logic [VCNT_W-1:0] msix_table_size_o,
    output logic pending_array_support_o
);
    // ========================================
    // mapping lookup
    function automatic logic [ICM_NQ-1:0] vec_causes(input logic [ICM_VMAP_W-1:0] map,
                                                     input int unsigned vec);
        logic [ICM_NQ-1:0] sel;
        sel = '0;
        for (int e = 0; e < ICM_NQ; e++)
        begin
            if (map[e*ICM_MAP_W+ICM_MAP_EN] &&
                (map[e*ICM_MAP_W +: ICM_VW] == ICM_VW'(vec)))
                sel[e] = 1'b1;
        end
        return sel;
    endfunction : vec_causes

    function automatic logic [ICM_DW-1:0] qpos(input logic [ICM_NQ-1:0] q);
        return ICM_DW'({{(ICM_DW-ICM_NQ){1'b0}}, q} << ICM_QLO);
    endfunction : qpos

    // ========================================
    // registers
    logic [ICM_DW-1:0] cause_r;
    logic [ICM_DW-1:0] cause_nxt;
    logic [ICM_DW-1:0] mask_r;
    logic [ICM_DW-1:0] mask_nxt;
    logic [ICM_DW-1:0] aclr_r;
    logic [ICM_DW-1:0] amsk_r;
    logic [ICM_VMAP_W-1:0] vmap_r;
    logic [ICM_ECTL_W-1:0] ectl_r;
    logic [VCNT_W-1:0] vcnt_r;
    logic [ICM_IVL_W-1:0] ivl_r [ICM_NVEC];
    logic [7:0] tick_r;
    logic [ICM_DW-1:0] rdata_r;
    logic [ICM_DW-1:0] rdata_nxt;
    logic intx_r;
    logic msg_req_r;
    logic [ICM_VW-1:0] msg_vec_r;

    // ========================================
    // decode
    wire logic wr_cause = reg_wr_i && (reg_addr_i == ICM_OFS_CAUSE);
    wire logic wr_cset = reg_wr_i && (reg_addr_i == ICM_OFS_CSET);
    wire logic wr_mset = reg_wr_i && (reg_addr_i == ICM_OFS_MSET);
    wire logic wr_mclr = reg_wr_i && (reg_addr_i == ICM_OFS_MCLR);
    wire logic wr_aclr = reg_wr_i && (reg_addr_i == ICM_OFS_ACLR);
    wire logic wr_amsk = reg_wr_i && (reg_addr_i == ICM_OFS_AMSK);
    wire logic wr_vmap = reg_wr_i && (reg_addr_i == ICM_OFS_VMAP);
    wire logic wr_ectl = reg_wr_i && (reg_addr_i == ICM_OFS_ECTL);
    wire logic rd_cause = reg_rd_i && (reg_addr_i == ICM_OFS_CAUSE);
    wire icm_mode_type mode = icm_mode_type'(ectl_r[1:0]);
    wire logic is_msix = (mode == ICM_MODE_MSIX);
    wire logic is_msi = (mode == ICM_MODE_MSI);
    wire logic is_legacy = (mode == ICM_MODE_LEGACY);
    wire logic amask_mode = ectl_r[ICM_ECTL_AMME];
    wire logic tick = (tick_r == '0);

    // ========================================
    // cause events
    wire logic [ICM_DW-1:0] cset_bits = wr_cset ? reg_wdata_i : ICM_RST_ZERO;
    wire logic [ICM_DW-1:0] ev_raw = cause_event_i | cset_bits;
    wire logic other_ev = |(ev_raw & ICM_NONQ_MASK);
    wire logic [ICM_DW-1:0] ev_other = ICM_DW'({{(ICM_DW-1){1'b0}}, other_ev} << ICM_OTHER);
    wire logic [ICM_DW-1:0] ev_set = ev_raw | ev_other;
    wire logic [ICM_DW-1:0] active = cause_r & mask_r;

    // ========================================
    // vector pending, throttle and grant
    logic [ICM_NVEC-1:0] pend;
    logic [ICM_NVEC-1:0] zero_w;
    logic [ICM_NVEC-1:0] grant;
    logic [ICM_VW-1:0] grant_idx;
    logic [ICM_NQ-1:0] fired_q;
    icm_thr_if thr_if [ICM_NVEC] ();

    genvar gv;
    generate
        for (gv = 0; gv < ICM_NVEC; gv++)
        begin : g_vec
            localparam logic [7:0] THR_OFS = ICM_OFS_THR0 + 8'(ICM_REG_STRIDE * gv);
            wire logic [ICM_NQ-1:0] vq = vec_causes(vmap_r, gv);
            wire logic q_pend = |(active[ICM_QLO +: ICM_NQ] & vq);
            wire logic msi_pend = (gv == 0) && (|active);
            assign pend[gv] = is_msix ? q_pend : (is_msi && msi_pend);
            assign thr_if[gv].interval = ivl_r[gv];
            assign thr_if[gv].tick = tick;
            assign thr_if[gv].grant = grant[gv];
            assign zero_w[gv] = thr_if[gv].zero;

            always_ff @(posedge clk_i or posedge rst_i)
            begin
                if (rst_i)
                    ivl_r[gv] <= '0;
                else if (reg_wr_i && (reg_addr_i == THR_OFS))
                    ivl_r[gv] <= reg_wdata_i[ICM_IVL_W-1:0];
            end

            icm_throttle u_thr (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .thr (thr_if[gv])
            );

            chk_thr_reload: assert property (
                @(posedge clk_i) disable iff (rst_i)
                (grant[gv] && (ivl_r[gv] != '0)) |=> !zero_w[gv] && !grant[gv])
                else $error("throttle counter not reloaded after message");
        end
    endgenerate

    always_comb
    begin
        grant = '0;
        grant_idx = '0;
        fired_q = '0;
        for (int v = ICM_NVEC - 1; v >= 0; v--)
        begin
            if (pend[v] && zero_w[v])
            begin
                grant = '0;
                grant[v] = 1'b1;
                grant_idx = ICM_VW'(v);
                fired_q = vec_causes(vmap_r, v);
            end
        end
    end

    // ========================================
    // automatic clear and mask
    wire logic [ICM_DW-1:0] fired_pos = is_msix ? qpos(fired_q) : ICM_RST_ZERO;
    wire logic [ICM_DW-1:0] aclr_hit = fired_pos & aclr_r & ICM_QRANGE_MASK;
    wire logic [ICM_DW-1:0] amsk_hit = amask_mode ? (fired_pos & amsk_r) : ICM_RST_ZERO;
    wire logic [ICM_DW-1:0] amsk_set = (!is_msix && wr_cause) ? (reg_wdata_i & amsk_r)
                                                              : ICM_RST_ZERO;
    wire logic [ICM_DW-1:0] wclr = wr_cause ? reg_wdata_i : ICM_RST_ZERO;
    wire logic [ICM_DW-1:0] rclr = (rd_cause && !is_msix) ? ~ICM_RST_ZERO : ICM_RST_ZERO;
    wire logic [ICM_DW-1:0] mset = wr_mset ? reg_wdata_i : ICM_RST_ZERO;
    wire logic [ICM_DW-1:0] mclr = wr_mclr ? reg_wdata_i : ICM_RST_ZERO;

    // set wins over every clear
    assign cause_nxt = (cause_r & ~(wclr | rclr | aclr_hit)) | ev_set;
    assign mask_nxt = (mask_r & ~(mclr | aclr_hit | amsk_hit)) | mset | amsk_set;

    // ========================================
    // read mux
    always_comb
    begin
        rdata_nxt = ICM_RST_ZERO;
        case (reg_addr_i)
            ICM_OFS_CAUSE: rdata_nxt = cause_r;
            ICM_OFS_MSET: rdata_nxt = mask_r;
            ICM_OFS_ACLR: rdata_nxt = aclr_r;
            ICM_OFS_AMSK: rdata_nxt = amsk_r;
            ICM_OFS_VMAP: rdata_nxt = ICM_DW'(vmap_r);
            ICM_OFS_ECTL: rdata_nxt = ICM_DW'(ectl_r);
            ICM_OFS_VCNT: rdata_nxt = ICM_DW'(vcnt_r);
            default:
            begin
                for (int v = 0; v < ICM_NVEC; v++)
                begin
                    if (reg_addr_i == ICM_OFS_THR0 + 8'(ICM_REG_STRIDE * v))
                        rdata_nxt = ICM_DW'(ivl_r[v]);
                end
            end
        endcase
        if (!reg_rd_i)
            rdata_nxt = ICM_RST_ZERO;
    end

    // ========================================
    // state
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cause_r <= ICM_RST_ZERO;
            mask_r <= ICM_RST_ZERO;
            aclr_r <= ICM_RST_ZERO;
            amsk_r <= ICM_RST_ZERO;
            vmap_r <= ICM_VMAP_RST;
            ectl_r <= '0;
            rdata_r <= ICM_RST_ZERO;
        end
        else
        begin
            cause_r <= cause_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            if (wr_aclr)
                aclr_r <= reg_wdata_i & ICM_QRANGE_MASK;
            if (wr_amsk)
                amsk_r <= reg_wdata_i;
            if (wr_vmap)
                vmap_r <= reg_wdata_i[ICM_VMAP_W-1:0];
            if (wr_ectl)
                ectl_r <= reg_wdata_i[ICM_ECTL_W-1:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            vcnt_r <= '0;
            tick_r <= ICM_TICK_LAST;
            intx_r <= 1'b0;
            msg_req_r <= 1'b0;
            msg_vec_r <= '0;
        end
        else
        begin
            if (nvm_load_i)
                vcnt_r <= nvm_vec_count_i;
            tick_r <= tick ? ICM_TICK_LAST : tick_r - 1'b1;
            intx_r <= is_legacy && (|active);
            msg_req_r <= |grant;
            msg_vec_r <= grant_idx;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign intx_o = intx_r;
    assign msg_req_o = msg_req_r;
    assign msg_vector_o = msg_vec_r;
    assign msix_table_size_o = vcnt_r;
    assign pending_array_support_o = ectl_r[ICM_ECTL_PBA];

    // ========================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_cause_capture: assert property (
        (|cause_event_i) |=> ((cause_r & $past(cause_event_i)) == $past(cause_event_i)))
        else $error("cause event not captured");
    chk_set_wins: assert property (
        (wr_cause && (|(reg_wdata_i & cause_event_i)))
        |=> ((cause_r & $past(cause_event_i)) == $past(cause_event_i)))
        else $error("event lost under clear");
    chk_other_summary: assert property (
        (|(cause_event_i & ICM_NONQ_MASK)) |=> cause_r[ICM_OTHER])
        else $error("other cause bit not set");
    chk_read_clear: assert property (
        (rd_cause && !is_msix && (cause_event_i == ICM_RST_ZERO))
        |=> (cause_r == ICM_RST_ZERO) && (reg_rdata_o == $past(cause_r)))
        else $error("cause read did not clear");
    chk_write_clear: assert property (
        (wr_cause && (cause_event_i == ICM_RST_ZERO))
        |=> ((cause_r & $past(reg_wdata_i)) == ICM_RST_ZERO))
        else $error("cause write did not clear");
    chk_cause_set: assert property (
        wr_cset |=> ((cause_r & $past(reg_wdata_i)) == $past(reg_wdata_i)))
        else $error("cause set write ignored");
    chk_irq_gate: assert property (
        (msg_req_o || intx_o) |-> ($past(active) != ICM_RST_ZERO))
        else $error("interrupt without unmasked cause");
    chk_mask_set: assert property (
        wr_mset |=> ((mask_r & $past(reg_wdata_i)) == $past(reg_wdata_i)))
        else $error("mask set write ignored");
    chk_mask_clear: assert property (
        wr_mclr |=> ((mask_r & $past(reg_wdata_i)) == ICM_RST_ZERO))
        else $error("mask clear write ignored");
    chk_mask_read: assert property (
        (reg_rd_i && (reg_addr_i == ICM_OFS_MSET)) |=> (reg_rdata_o == $past(mask_r)))
        else $error("mask read wrong");
    chk_auto_clear: assert property (
        ((|aclr_hit) && !wr_mset && (cause_event_i == ICM_RST_ZERO) && !wr_cset)
        |=> (((cause_r | mask_r) & $past(aclr_hit)) == ICM_RST_ZERO))
        else $error("auto clear did not act");
    chk_vec_load: assert property (
        nvm_load_i |=> (msix_table_size_o == $past(nvm_vec_count_i)))
        else $error("vector count not loaded");
    chk_legacy_line: assert property (
        (is_legacy && (|active)) |=> intx_o)
        else $error("legacy line not raised");
    chk_auto_mask_set: assert property (
        (|amsk_set) |=> ((mask_r & $past(amsk_set)) == $past(amsk_set)))
        else $error("auto mask did not set");
    chk_auto_mask_vec: assert property (
        ((|amsk_hit) && !wr_mset)
        |=> ((mask_r & $past(amsk_hit)) == ICM_RST_ZERO))
        else $error("auto mask did not clear");

    cov_msix_msg: cover property ((is_msix && msg_req_o) ##[1:40] msg_req_o);
    cov_legacy_line: cover property (is_legacy ##1 intx_o);
    cov_auto_clear: cover property (|aclr_hit);
    cov_set_race: cover property (wr_cause && (|(reg_wdata_i & cause_event_i)));
endmodule : icm_top
`default_nettype wire

// [icm_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ========================================
// host side: takes every message, notes vector and spacing
module icm_host_model
    import icm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // device signalling
    input wire logic msg_req_i,
    input wire logic [ICM_VW-1:0] msg_vector_i,
    // observations
    output var logic [15:0] msg_count_o,
    output var logic [ICM_VW-1:0] last_vector_o,
    output var logic [15:0] last_gap_o
);
    logic [15:0] cyc_r;
    logic [15:0] last_cyc_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cyc_r <= 16'h0000;
            last_cyc_r <= 16'h0000;
            msg_count_o <= 16'h0000;
            last_vector_o <= '0;
            last_gap_o <= 16'h0000;
        end
        else
        begin
            cyc_r <= cyc_r + 16'h0001;
            // host accepts a message in any cycle, never stalls
            if (msg_req_i)
            begin
                msg_count_o <= msg_count_o + 16'h0001;
                last_vector_o <= msg_vector_i;
                last_gap_o <= cyc_r - last_cyc_r;
                last_cyc_r <= cyc_r;
            end
        end
    end
endmodule : icm_host_model
`default_nettype wire

// [icm_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
module icm_top_test
    import icm_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [31:0] cause_event_i = 32'h0000_0000;
    logic nvm_load_i = 1'b0;
    logic [ICM_CNT_W-1:0] nvm_vec_count_i = 11'h000;
    logic intx_o;
    logic msg_req_o;
    logic [ICM_VW-1:0] msg_vector_o;
    logic [ICM_CNT_W-1:0] msix_table_size_o;
    logic pending_array_support_o;
    logic [15:0] msg_count;
    logic [ICM_VW-1:0] last_vector;
    logic [15:0] last_gap;
    int fail_count = 0;
    int comparisons = 0;

    always #10 clk_i = ~clk_i;

    icm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cause_event_i(cause_event_i), .nvm_load_i(nvm_load_i),
        .nvm_vec_count_i(nvm_vec_count_i), .intx_o(intx_o), .msg_req_o(msg_req_o),
        .msg_vector_o(msg_vector_o), .msix_table_size_o(msix_table_size_o),
        .pending_array_support_o(pending_array_support_o));

    icm_host_model host (.clk_i(clk_i), .rst_i(rst_i), .msg_req_i(msg_req_o),
        .msg_vector_i(msg_vector_o), .msg_count_o(msg_count), .last_vector_o(last_vector),
        .last_gap_o(last_gap));

    // ========================================
    // helpers
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check($sformatf("read %h", a), reg_rdata_o, exp);
    endtask : rd

    task automatic ev(input logic [31:0] b);
        @(posedge clk_i);
        cause_event_i <= b;
        @(posedge clk_i);
        cause_event_i <= 32'h0000_0000;
    endtask : ev

    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic wait_msg(input int bound, input logic [2:0] vec);
        logic [15:0] n0;
        n0 = msg_count;
        for (int i = 0; i < bound && msg_count === n0; i++)
            @(posedge clk_i);
        #1;
        check("message seen", {31'h0, msg_count !== n0}, 32'h0000_0001);
        check("message vector", {29'h0, last_vector}, {29'h0, vec});
    endtask : wait_msg

    // ========================================
    // scenarios
    task automatic t_reset_values();
        rd(ICM_OFS_CAUSE, 32'h0000_0000);
        rd(ICM_OFS_MSET, 32'h0000_0000);
        rd(ICM_OFS_ACLR, 32'h0000_0000);
        rd(ICM_OFS_AMSK, 32'h0000_0000);
        rd(ICM_OFS_VMAP, 32'h000C_BA98);
        rd(ICM_OFS_ECTL, 32'h0000_0000);
        rd(ICM_OFS_CSET, 32'h0000_0000);
        rd(8'h3C, 32'h0000_0000);
    endtask : t_reset_values

    task automatic t_legacy();
        ev(32'h0000_0008);
        rd(ICM_OFS_CAUSE, 32'h0000_0008);
        rd(ICM_OFS_CAUSE, 32'h0000_0000);
        ev(32'h0000_0200);
        rd(ICM_OFS_CAUSE, 32'h0100_0200);
        wr(ICM_OFS_CSET, 32'h0000_00F0);
        wr(ICM_OFS_CAUSE, 32'h0000_0030); // clearing side of software
        rd(ICM_OFS_CAUSE, 32'h0000_00C0);
        wr(ICM_OFS_CSET, 32'h0000_0080);
        settle();
        check("intx masked", {31'h0, intx_o}, 32'h0000_0000);
        wr(ICM_OFS_MSET, 32'h0000_0080);
        settle();
        check("intx unmasked", {31'h0, intx_o}, 32'h0000_0001);
        wr(ICM_OFS_MSET, 32'h0000_0001);
        rd(ICM_OFS_MSET, 32'h0000_0081);
        wr(ICM_OFS_MCLR, 32'h0000_0080);
        settle();
        check("intx cleared", {31'h0, intx_o}, 32'h0000_0000);
        rd(ICM_OFS_MSET, 32'h0000_0001);
        wr(ICM_OFS_MCLR, 32'h0000_0001);
        rd(ICM_OFS_CAUSE, 32'h0000_0080);
        wr(ICM_OFS_AMSK, 32'h0000_0040);
        wr(ICM_OFS_CSET, 32'h0000_0040);
        wr(ICM_OFS_CAUSE, 32'h0000_0040);
        rd(ICM_OFS_MSET, 32'h0000_0040);
        wr(ICM_OFS_MCLR, 32'h0000_0040);
        wr(ICM_OFS_CSET, 32'h0000_0020);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= ICM_OFS_CAUSE;
        reg_wdata_i <= 32'h0000_0020;
        cause_event_i <= 32'h0000_0020;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        cause_event_i <= 32'h0000_0000;
        rd(ICM_OFS_CAUSE, 32'h0000_0020);
        check("no message in legacy", {16'h0, msg_count}, 32'h0000_0000);
    endtask : t_legacy

    task automatic t_msi();
        wr(ICM_OFS_ECTL, 32'h0000_0001);
        wr(ICM_OFS_MSET, 32'h0000_0008);
        wr(ICM_OFS_CSET, 32'h0000_0008);
        wait_msg(6, 3'h0);
        check("intx in msi", {31'h0, intx_o}, 32'h0000_0000);
        wr(ICM_OFS_MCLR, 32'h0000_0008);
        rd(ICM_OFS_CAUSE, 32'h0000_0008);
    endtask : t_msi

    task automatic t_msix_auto_clear();
        wr(ICM_OFS_ECTL, 32'h0000_000A); // pending-array support with vector mode
        settle();
        check("pending support", {31'h0, pending_array_support_o}, 32'h0000_0001);
        wr(ICM_OFS_ACLR, 32'hFFFF_FFFF);
        rd(ICM_OFS_ACLR, 32'h01F0_0000);
        wr(ICM_OFS_MSET, 32'h0050_0000);
        wr(ICM_OFS_CSET, 32'h0010_0000);
        wait_msg(6, 3'h0);
        settle();
        rd(ICM_OFS_CAUSE, 32'h0000_0000);
        rd(ICM_OFS_MSET, 32'h0040_0000);
        wr(ICM_OFS_VMAP, 32'h000C_BC98);
        rd(ICM_OFS_VMAP, 32'h000C_BC98);
        wr(ICM_OFS_CSET, 32'h0040_0000);
        wait_msg(6, 3'h4);
        settle();
        rd(ICM_OFS_MSET, 32'h0000_0000);
        wr(ICM_OFS_MSET, 32'h0100_0000);
        ev(32'h0000_0004);
        wait_msg(6, 3'h4);
        settle();
        rd(ICM_OFS_CAUSE, 32'h0000_0004);
        rd(ICM_OFS_CAUSE, 32'h0000_0004);
        wr(ICM_OFS_CAUSE, 32'hFFFF_FFFF);
        rd(ICM_OFS_CAUSE, 32'h0000_0000);
    endtask : t_msix_auto_clear

    task automatic t_msix_auto_mask();
        wr(ICM_OFS_ECTL, 32'h0000_000E);
        wr(ICM_OFS_ACLR, 32'h01D0_0000);
        wr(ICM_OFS_AMSK, 32'h0020_0000);
        wr(ICM_OFS_MSET, 32'h0020_0000);
        wr(ICM_OFS_CSET, 32'h0020_0000);
        wait_msg(6, 3'h1);
        settle();
        rd(ICM_OFS_MSET, 32'h0000_0000);
        rd(ICM_OFS_CAUSE, 32'h0020_0000);
        wr(ICM_OFS_CAUSE, 32'h0020_0000);
        rd(ICM_OFS_MSET, 32'h0000_0000);
        rd(ICM_OFS_CAUSE, 32'h0000_0000);
    endtask : t_msix_auto_mask

    task automatic t_throttle();
        wr(ICM_OFS_ECTL, 32'h0000_000A);
        wr(ICM_OFS_ACLR, 32'h0000_0000);
        wr(ICM_OFS_AMSK, 32'h0000_0000);
        wr(ICM_OFS_THR0 + 8'h0C, 32'h0000_0002);
        wr(ICM_OFS_MSET, 32'h0080_0000);
        wr(ICM_OFS_CSET, 32'h0080_0000);
        wait_msg(4, 3'h3);
        wait_msg(40, 3'h3);
        check("throttle gap", {31'h0, last_gap > 16'(ICM_TICK_CYC)
            && last_gap <= 16'(2 * ICM_TICK_CYC + 3)}, 32'h0000_0001);
        wr(ICM_OFS_MCLR, 32'h0080_0000);
        wr(ICM_OFS_CAUSE, 32'h0080_0000);
    endtask : t_throttle

    task automatic t_nvm();
        @(posedge clk_i);
        nvm_load_i <= 1'b1;
        nvm_vec_count_i <= 11'h004;
        @(posedge clk_i);
        nvm_load_i <= 1'b0;
        settle();
        check("table size", {21'h0, msix_table_size_o}, 32'h0000_0004);
        rd(ICM_OFS_VCNT, 32'h0000_0004);
    endtask : t_nvm

    // ========================================
    // main sequence and watchdog
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        t_legacy();
        t_msi();
        t_msix_auto_clear();
        t_msix_auto_mask();
        t_throttle();
        t_nvm();
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end
endmodule : icm_top_test
`default_nettype wire
